//--- design/bos_fifo.sv
// Parameterised valid/ready FIFO for queued port writes
`timescale 1ns/1ps
module bos_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	if (DEPTH < 2 || WIDTH < 1) begin : g_check
		$error("bos_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
	} bos_fifo_st_t;

	bos_fifo_st_t s;
	bos_fifo_st_t next_s;
	logic push;
	logic pop;

	assign in_ready = s.cnt != FULL;
	assign out_valid = s.cnt != '0;
	assign out_data = s.mem[s.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = in_data;
			next_s.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
		end
		if (pop) begin
			next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
		end
		if (push && !pop) begin
			next_s.cnt = s.cnt + 1'b1;
		end else if (pop && !push) begin
			next_s.cnt = s.cnt - 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	a_fifo_order: assert property (@(posedge mclk) disable iff (!nrst)
		(push && s.cnt == '0 && !pop) |=> (out_valid && out_data == $past(in_data)))
		else $error("FIFO head differs from byte written into empty FIFO");
endmodule : bos_fifo

//--- design/bos_pkg.sv
// Constants for the block port output sequencer
package bos_pkg;
	localparam logic [7:0] BOS_OP_PREFIX = 8'hED;
	localparam logic [7:0] BOS_OP_REP_INC = 8'hB3;
	localparam logic [7:0] BOS_OP_SINGLE_DEC = 8'hAB;
	localparam logic [7:0] BOS_OP_REP_DEC = 8'hBB;
	localparam logic [2:0] BOS_M1_LEN = 3'h4;
	localparam logic [2:0] BOS_M2_LEN = 3'h5;
	localparam logic [2:0] BOS_M3_LEN = 3'h3;
	localparam logic [2:0] BOS_M4_LEN = 3'h4;
	localparam logic [2:0] BOS_M5_LEN = 3'h5;
	localparam logic [2:0] BOS_REFRESH_T0 = 3'h1;
	localparam logic [2:0] BOS_REFRESH_T1 = 3'h3;
	localparam logic [15:0] BOS_PC_STEP = 16'h0002;
	localparam int BOS_FLAG_Z = 6;
	localparam int BOS_FLAG_N = 1;
	localparam logic [7:0] BOS_ADR_CMD = 8'h00;
	localparam logic [7:0] BOS_ADR_PORT = 8'h04;
	localparam logic [7:0] BOS_ADR_COUNT = 8'h08;
	localparam logic [7:0] BOS_ADR_POINTER = 8'h0C;
	localparam logic [7:0] BOS_ADR_PC = 8'h10;
	localparam logic [7:0] BOS_ADR_FLAGS = 8'h14;
	localparam logic [7:0] BOS_ADR_TSTATES = 8'h18;
	localparam logic [31:0] BOS_RST_VALUE = 32'h0000_0000;
	localparam int BOS_FIFO_DEPTH = 8;
	localparam int BOS_FIFO_WIDTH = 24;
endpackage : bos_pkg

//--- design/bos_seq.sv
// Block port output sequencer with Wishbone register access
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module bos_seq #(
	parameter int FIFO_DEPTH = bos_pkg::BOS_FIFO_DEPTH
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	output logic mem_rd,
	output logic [15:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	input wire logic mem_ack,
	output logic io_wr,
	output logic [15:0] io_addr,
	output logic [7:0] io_data,
	input wire logic io_ready,
	input wire logic int_req,
	output logic refresh,
	output logic busy
);
	typedef enum logic [2:0] {st_idle, st_m1, st_m2, st_m3, st_m4, st_m5} bos_st_t;
	typedef enum logic [1:0] {single_output_decrement, repeat_output_increment, repeat_output_decrement} bos_mode_t;

	typedef struct packed {
		bos_st_t st;
		logic [2:0] t;
		bos_mode_t mode;
		logic prefix;
		logic illegal;
		logic intr;
		logic [7:0] port;
		logic [7:0] cnt;
		logic [15:0] memory_pointer_pair;
		logic [15:0] program_counter;
		logic [7:0] flags;
		logic [7:0] hold;
		logic got;
		logic pushed;
		logic stalled;
		logic [7:0] it_cnt;
		logic [7:0] last_t;
		logic [2:0] sync;
		logic int_lvl;
		logic refresh;
		logic ack;
		logic [31:0] rdata;
	} bos_state_t;

	bos_state_t s;
	bos_state_t next_s;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic [23:0] fifo_in_data;
	logic [23:0] fifo_out_data;
	logic adv;
	logic last_t;
	logic wb_req;
	logic cmd_wr;

	if (FIFO_DEPTH < 2) begin : g_check
		$error("bos_seq needs FIFO_DEPTH of at least 2");
	end

	function automatic logic [2:0] mlen(input bos_st_t st);
		unique case (st)
			st_m1: mlen = bos_pkg::BOS_M1_LEN;
			st_m2: mlen = bos_pkg::BOS_M2_LEN;
			st_m3: mlen = bos_pkg::BOS_M3_LEN;
			st_m4: mlen = bos_pkg::BOS_M4_LEN;
			st_m5: mlen = bos_pkg::BOS_M5_LEN;
			st_idle: mlen = 3'h1;
		endcase
	endfunction : mlen

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = wr[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [7:0] set_flags(input logic [7:0] old, input logic z);
		logic [7:0] f;
		f = old;
		f[bos_pkg::BOS_FLAG_Z] = z;
		f[bos_pkg::BOS_FLAG_N] = 1'b1;
		return f;
	endfunction : set_flags

	// Handshakes toward memory and FIFO
	assign mem_rd = s.st == st_m3 && s.t == 3'h0 && !s.got;
	assign mem_addr = s.memory_pointer_pair;
	assign fifo_in_valid = s.st == st_m4 && s.t == 3'h0 && !s.pushed;
	assign fifo_in_data = {s.cnt, s.port, s.hold};
	assign io_addr = fifo_out_data[23:8];
	assign io_data = fifo_out_data[7:0];
	assign wb_dat_r = s.rdata;
	assign wb_ack = s.ack;
	assign refresh = s.refresh;
	assign busy = s.st != st_idle;
	assign wb_req = wb_cyc && wb_stb && !s.ack;
	assign cmd_wr = wb_req && wb_we && s.st == st_idle && wb_adr == bos_pkg::BOS_ADR_CMD && wb_sel[0] && s.prefix;

	always_comb begin
		adv = 1'b1;
		if (s.st == st_m3 && s.t == 3'h0) begin
			adv = s.got || mem_ack;
		end else if (s.st == st_m4 && s.t == 3'h0) begin
			adv = s.pushed || fifo_in_ready;
		end
		last_t = s.st != st_idle && adv && s.t == mlen(s.st) - 3'h1;
	end

	always_comb begin
		next_s = s;
		next_s.refresh = 1'b0;
		// Interrupt pin: three stages, level taken when stages two and three agree
		next_s.sync = {s.sync[1:0], int_req};
		if (s.sync[1] == s.sync[2]) begin
			next_s.int_lvl = s.sync[2];
		end
		// Wishbone slave, ack one cycle after request
		next_s.ack = wb_req;
		if (wb_req && !wb_we) begin
			unique case (wb_adr)
				bos_pkg::BOS_ADR_CMD: next_s.rdata = {27'h0, s.illegal, s.intr, s.prefix, busy, 1'b0} >> 1;
				bos_pkg::BOS_ADR_PORT: next_s.rdata = {24'h0, s.port};
				bos_pkg::BOS_ADR_COUNT: next_s.rdata = {24'h0, s.cnt};
				bos_pkg::BOS_ADR_POINTER: next_s.rdata = {16'h0, s.memory_pointer_pair};
				bos_pkg::BOS_ADR_PC: next_s.rdata = {16'h0, s.program_counter};
				bos_pkg::BOS_ADR_FLAGS: next_s.rdata = {24'h0, s.flags};
				bos_pkg::BOS_ADR_TSTATES: next_s.rdata = {24'h0, s.last_t};
				default: next_s.rdata = 32'h0;
			endcase
		end
		if (wb_req && wb_we && s.st == st_idle) begin
			unique case (wb_adr)
				bos_pkg::BOS_ADR_CMD: begin
					if (wb_sel[0]) begin
						if (!s.prefix) begin
							next_s.prefix = wb_dat_w[7:0] == bos_pkg::BOS_OP_PREFIX;
							next_s.illegal = wb_dat_w[7:0] != bos_pkg::BOS_OP_PREFIX;
						end else begin
							next_s.prefix = 1'b0;
							next_s.illegal = 1'b0;
							next_s.intr = 1'b0;
							next_s.st = st_m1;
							next_s.t = 3'h0;
							next_s.it_cnt = 8'h0;
							next_s.stalled = 1'b0;
							next_s.got = 1'b0;
							next_s.pushed = 1'b0;
							unique case (wb_dat_w[7:0])
								bos_pkg::BOS_OP_REP_INC: next_s.mode = repeat_output_increment;
								bos_pkg::BOS_OP_SINGLE_DEC: next_s.mode = single_output_decrement;
								bos_pkg::BOS_OP_REP_DEC: next_s.mode = repeat_output_decrement;
								default: begin
									next_s.st = st_idle;
									next_s.illegal = 1'b1;
								end
							endcase
						end
					end
				end
				bos_pkg::BOS_ADR_PORT: next_s.port = 8'(merge({24'h0, s.port}, wb_dat_w, wb_sel));
				bos_pkg::BOS_ADR_COUNT: next_s.cnt = 8'(merge({24'h0, s.cnt}, wb_dat_w, wb_sel));
				bos_pkg::BOS_ADR_POINTER: next_s.memory_pointer_pair =
					16'(merge({16'h0, s.memory_pointer_pair}, wb_dat_w, wb_sel));
				bos_pkg::BOS_ADR_PC: next_s.program_counter =
					16'(merge({16'h0, s.program_counter}, wb_dat_w, wb_sel));
				bos_pkg::BOS_ADR_FLAGS: next_s.flags = 8'(merge({24'h0, s.flags}, wb_dat_w, wb_sel));
				default: ;
			endcase
		end
		// Sequencer
		if (s.st != st_idle) begin
			next_s.it_cnt = s.it_cnt + 8'h1;
			if (!adv) begin
				next_s.stalled = 1'b1;
			end else begin
				next_s.t = last_t ? 3'h0 : s.t + 3'h1;
			end
			if (mem_rd && mem_ack) begin
				next_s.got = 1'b1;
				next_s.hold = mem_rdata;
			end
			if (fifo_in_valid && fifo_in_ready) begin
				next_s.pushed = 1'b1;
			end
			if (s.st == st_m5 && (s.t == bos_pkg::BOS_REFRESH_T0 || s.t == bos_pkg::BOS_REFRESH_T1)) begin
				next_s.refresh = 1'b1;
			end
			if (last_t) begin
				unique case (s.st)
					st_m1: next_s.st = st_m2;
					st_m2: next_s.st = st_m3;
					st_m3: begin
						next_s.st = st_m4;
						next_s.cnt = s.cnt - 8'h1;
					end
					st_m4: begin
						if (s.mode == repeat_output_increment) begin
							next_s.memory_pointer_pair = s.memory_pointer_pair + 16'h1;
						end else begin
							next_s.memory_pointer_pair = s.memory_pointer_pair - 16'h1;
						end
						if (s.mode == single_output_decrement) begin
							next_s.st = st_idle;
							next_s.flags = set_flags(s.flags, s.cnt == 8'h0);
							next_s.last_t = s.it_cnt + 8'h1;
						end else if (s.cnt == 8'h0) begin
							next_s.st = st_idle;
							next_s.flags = set_flags(s.flags, 1'b1);
							next_s.last_t = s.it_cnt + 8'h1;
						end else begin
							next_s.st = st_m5;
						end
					end
					st_m5: begin
						next_s.program_counter = s.program_counter - bos_pkg::BOS_PC_STEP;
						next_s.last_t = s.it_cnt + 8'h1;
						next_s.it_cnt = 8'h0;
						next_s.stalled = 1'b0;
						next_s.got = 1'b0;
						next_s.pushed = 1'b0;
						if (s.int_lvl) begin
							next_s.st = st_idle;
							next_s.intr = 1'b1;
						end else begin
							next_s.st = st_m1;
						end
					end
					st_idle: next_s.st = st_idle;
				endcase
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s <= bos_state_t'(bos_pkg::BOS_RST_VALUE);
		end else begin
			s <= next_s;
		end
	end

	bos_fifo #(
		.WIDTH(bos_pkg::BOS_FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.nrst(nrst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in_data),
		.out_valid(io_wr),
		.out_ready(io_ready),
		.out_data(fifo_out_data)
	);

	a_iter_length: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m5 && last_t && !s.stalled) |-> s.it_cnt == 8'h14)
		else $error("Continuing iteration did not take 21 states");
	a_final_length: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m4 && last_t && !s.stalled && (s.mode == single_output_decrement || s.cnt == 8'h0))
		|-> s.it_cnt == 8'h0F)
		else $error("Final or single transfer did not take 16 states");
	a_port_address: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m3 && last_t) |=> ##[0:300] (fifo_in_valid && fifo_in_data[23:8] == {$past(s.cnt) - 8'h1, s.port}))
		else $error("Port write address not decremented counter and port select");
	a_ptr_step: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m4 && last_t) |=> s.memory_pointer_pair ==
		(($past(s.mode) == repeat_output_increment) ? $past(s.memory_pointer_pair) + 16'h1
		: $past(s.memory_pointer_pair) - 16'h1))
		else $error("Pointer pair did not step in the selected direction");
	a_pc_back: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m5 && last_t) |=> s.program_counter == $past(s.program_counter) - 16'h2)
		else $error("Program counter not reduced by two on repeat");
	a_refresh_two: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m5 && s.t == 3'h0) |-> ##2 refresh ##1 !refresh ##1 refresh ##1 !refresh)
		else $error("Two refresh pulses not seen after transfer");
	a_single_flags: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m4 && last_t && s.mode == single_output_decrement) |=>
		(s.flags[bos_pkg::BOS_FLAG_Z] == ($past(s.cnt) == 8'h0) && s.flags[bos_pkg::BOS_FLAG_N]
		&& s.flags[0] == $past(s.flags[0]) && !busy))
		else $error("Single transfer flags wrong");
	a_repeat_end: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m4 && last_t && s.mode != single_output_decrement && s.cnt == 8'h0) |=>
		(s.flags[bos_pkg::BOS_FLAG_Z] && s.flags[bos_pkg::BOS_FLAG_N] && !busy))
		else $error("Repeat completion flags wrong");
	a_mem_hold: assert property (@(posedge mclk) disable iff (!nrst)
		(mem_rd && mem_ack) |=> (s.hold == $past(mem_rdata) && !mem_rd))
		else $error("Fetched byte not held");
	a_prefix_need: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_idle && !s.prefix) |=> s.st == st_idle)
		else $error("Execution began without prefix byte");
	a_op_inc: assert property (@(posedge mclk) disable iff (!nrst)
		(cmd_wr && wb_dat_w[7:0] == bos_pkg::BOS_OP_REP_INC)
		|=> (s.st == st_m1 && s.mode == repeat_output_increment))
		else $error("Second byte for incrementing repeat not decoded");
	a_op_single: assert property (@(posedge mclk) disable iff (!nrst)
		(cmd_wr && wb_dat_w[7:0] == bos_pkg::BOS_OP_SINGLE_DEC)
		|=> (s.st == st_m1 && s.mode == single_output_decrement))
		else $error("Second byte for single transfer not decoded");
	a_op_dec: assert property (@(posedge mclk) disable iff (!nrst)
		(cmd_wr && wb_dat_w[7:0] == bos_pkg::BOS_OP_REP_DEC)
		|=> (s.st == st_m1 && s.mode == repeat_output_decrement))
		else $error("Second byte for decrementing repeat not decoded");
	a_count_step: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m3 && last_t) |=> s.cnt == $past(s.cnt) - 8'h1)
		else $error("Byte counter did not step down by one");
	a_io_hold: assert property (@(posedge mclk) disable iff (!nrst)
		(io_wr && !io_ready) |=> (io_wr && $stable(io_addr) && $stable(io_data)))
		else $error("Port write word changed before it was taken");
	a_mem_wait: assert property (@(posedge mclk) disable iff (!nrst)
		(mem_rd && !mem_ack) |=> (mem_rd && $stable(mem_addr)))
		else $error("Memory read dropped before it was answered");
	a_single_end: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m4 && last_t && s.mode == single_output_decrement)
		|=> (s.st == st_idle && s.program_counter == $past(s.program_counter)))
		else $error("Single transfer repeated or moved the program counter");
	a_repeat_go: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m4 && last_t && s.mode != single_output_decrement && s.cnt != 8'h0) |=> s.st == st_m5)
		else $error("Repeat with nonzero counter did not continue");
	a_repeat_carry: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m4 && last_t && s.mode != single_output_decrement && s.cnt == 8'h0)
		|=> s.flags[0] == $past(s.flags[0]))
		else $error("Carry changed at repeat completion");
	a_refresh_only: assert property (@(posedge mclk) disable iff (!nrst)
		refresh |-> (s.st == st_m5 && s.mode != single_output_decrement))
		else $error("Refresh pulse outside a continuing repeat");
	a_int_stop: assert property (@(posedge mclk) disable iff (!nrst)
		(s.st == st_m5 && last_t && s.int_lvl) |=> (!busy && s.intr))
		else $error("Pending interrupt not accepted after transfer");
	a_ack_once: assert property (@(posedge mclk) disable iff (!nrst)
		wb_ack |=> !wb_ack)
		else $error("Bus acknowledge held longer than one cycle");
	a_busy_refuse: assert property (@(posedge mclk) disable iff (!nrst)
		(wb_req && wb_we && busy && wb_adr == bos_pkg::BOS_ADR_PORT) |=> s.port == $past(s.port))
		else $error("Port select written while an instruction ran");
endmodule : bos_seq

//--- tb/block_port_output_sequencer_tb.sv
// Self-checking testbench for the block port output sequencer
`timescale 1ns/1ps
module block_port_output_sequencer_tb;
	logic mclk, nrst, wb_cyc, wb_stb, wb_we, wb_ack, mem_rd, mem_ack, io_wr, io_ready, int_req, refresh, busy;
	logic slow, hold;
	logic [7:0] wb_adr, mem_rdata, io_data;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat_w, wb_dat_r, q;
	logic [15:0] mem_addr, io_addr;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int ref_cnt = 0;
	int base;
	bos_seq i_dut (.mclk(mclk), .nrst(nrst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
		.wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .io_wr(io_wr), .io_addr(io_addr),
		.io_data(io_data), .io_ready(io_ready), .int_req(int_req), .refresh(refresh), .busy(busy));
	bos_part_model i_part (.mclk(mclk), .nrst(nrst), .slow(slow), .hold(hold), .mem_rd(mem_rd),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .io_wr(io_wr), .io_addr(io_addr),
		.io_data(io_data), .io_ready(io_ready));
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hC3;
	endfunction : pat
	task automatic tally_and_finish;
		$display("Checks run %0d, errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		wb_sel <= 4'hF;
		do @(posedge mclk); while (wb_ack !== 1'b1);
		q = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge mclk);
	endtask : wb
	task automatic setup(input logic [7:0] port, cnt, input logic [15:0] ptr, pc, input logic [7:0] fl);
		wb(1'b1, 8'h04, {24'h0, port});
		wb(1'b1, 8'h08, {24'h0, cnt});
		wb(1'b1, 8'h0C, {16'h0, ptr});
		wb(1'b1, 8'h10, {16'h0, pc});
		wb(1'b1, 8'h14, {24'h0, fl});
		base = i_part.n;
		ref_cnt = 0;
	endtask : setup
	task automatic start(input logic [7:0] op);
		wb(1'b1, 8'h00, 32'h0000_00ED);
		wb(1'b1, 8'h00, {24'h0, op});
	endtask : start
	task automatic finish_and_check(input logic [15:0] ptr, pc, input logic [31:0] fl, ts);
		while (busy !== 1'b0 || io_wr !== 1'b0) @(posedge mclk);
		wb(1'b0, 8'h0C, 32'h0);
		chk(q, {16'h0, ptr}, "pointer");
		wb(1'b0, 8'h10, 32'h0);
		chk(q, {16'h0, pc}, "program counter");
		wb(1'b0, 8'h14, 32'h0);
		chk(q & 32'h43, fl, "flags");
		wb(1'b0, 8'h18, 32'h0);
		chk(q, ts, "states");
	endtask : finish_and_check
	task automatic t_reset;
		for (int a = 0; a < 9; a++) begin
			wb(1'b0, 8'(a * 4), 32'h0);
			chk(q, 32'h0, "reset value");
		end
		wb(1'b1, 8'h1C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h1C, 32'h0);
		chk(q, 32'h0, "unmapped");
	endtask : t_reset
	task automatic t_single(input logic [7:0] c);
		setup(8'h07, c, 16'h1000, 16'h0100, 8'h01);
		start(8'hAB);
		finish_and_check(16'h0FFF, 16'h0100, {25'h0, c == 8'h01, 4'h0, 2'h3}, 32'd16);
		chk(i_part.n - base, 1, "single count");
		chk(i_part.log[base], {c - 8'h01, 8'h07, pat(16'h1000)}, "single word");
	endtask : t_single
	task automatic t_rep_inc;
		setup(8'h5A, 8'h0A, 16'h1000, 16'h0100, 8'h00);
		slow <= 1'b1;
		hold <= 1'b1;
		start(8'hB3);
		repeat (400) @(posedge mclk);
		chk({31'h0, busy}, 32'h1, "stalled on full buffer");
		chk(i_part.n - base, 0, "no word while held");
		hold <= 1'b0;
		// Final pass: 16 states plus two memory wait states
		finish_and_check(16'h100A, 16'h00EE, 32'h42, 32'd18);
		chk(ref_cnt, 18, "refresh pulses");
		for (int k = 0; k < 10; k++) begin
			chk(i_part.log[base + k], {8'(9 - k), 8'h5A, pat(16'(4096 + k))}, "inc word");
		end
		slow <= 1'b0;
	endtask : t_rep_inc
	task automatic t_rep_wrap;
		setup(8'h3C, 8'h00, 16'h2000, 16'h0200, 8'h01);
		start(8'hBB);
		wb(1'b1, 8'h04, 32'h0000_00FF);
		finish_and_check(16'h1F00, 16'h0002, 32'h43, 32'd16);
		chk(i_part.n - base, 256, "wrap count");
		for (int k = 0; k < 256; k++) begin
			chk(i_part.log[base + k], {8'(255 - k), 8'h3C, pat(16'(8192 - k))}, "dec word");
		end
	endtask : t_rep_wrap
	task automatic t_interrupt;
		setup(8'h11, 8'h05, 16'h3000, 16'h0100, 8'h00);
		start(8'hB3);
		int_req <= 1'b1;
		while (busy !== 1'b0) @(posedge mclk);
		int_req <= 1'b0;
		wb(1'b0, 8'h00, 32'h0);
		chk(q & 32'h4, 32'h4, "interrupted status");
		chk((i_part.n - base) < 5 && (i_part.n - base) > 0, 1, "stopped early");
	endtask : t_interrupt
	task automatic t_illegal;
		wb(1'b1, 8'h00, 32'h0000_0000);
		wb(1'b0, 8'h00, 32'h0);
		chk(q & 32'hB, 32'h8, "bad prefix");
		start(8'h77);
		wb(1'b0, 8'h00, 32'h0);
		chk(q & 32'hB, 32'h8, "bad second byte");
	endtask : t_illegal
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (refresh === 1'b1) ref_cnt++;
		if (cyc == 40000) begin
			errors++;
			tally_and_finish();
		end
	end
	initial begin
		{nrst, wb_cyc, wb_stb, wb_we, int_req, slow, hold} <= 7'h00;
		wb_adr <= 8'h00;
		wb_sel <= 4'hF;
		wb_dat_w <= 32'h0;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		t_reset();
		t_single(8'h10);
		t_single(8'h01);
		t_rep_inc();
		t_rep_wrap();
		t_interrupt();
		t_illegal();
		tally_and_finish();
	end
endmodule : block_port_output_sequencer_tb

//--- tb/bos_part_model.sv
// Memory and port peripheral model on the far side of the sequencer
`timescale 1ns/1ps
module bos_part_model (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic hold,
	input wire logic mem_rd,
	input wire logic [15:0] mem_addr,
	output logic [7:0] mem_rdata,
	output logic mem_ack,
	input wire logic io_wr,
	input wire logic [15:0] io_addr,
	input wire logic [7:0] io_data,
	output logic io_ready
);
	logic [1:0] rd_wait;
	logic [1:0] io_wait;
	logic [23:0] log [0:511];
	int n = 0;
	function automatic logic [7:0] pat(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'hC3;
	endfunction : pat
	// Byte at the pointer address, inverted while not answering
	assign mem_ack = mem_rd && (!slow || rd_wait == 2'h2);
	assign mem_rdata = mem_ack ? pat(mem_addr) : ~pat(mem_addr);
	// Peripheral takes the byte when io_wr and io_ready meet
	assign io_ready = io_wr && !hold && (!slow || io_wait == 2'h3);
	always @(posedge mclk) begin
		rd_wait <= (nrst && mem_rd && !mem_ack) ? rd_wait + 2'h1 : 2'h0;
		io_wait <= (nrst && io_wr && !io_ready && !hold) ? io_wait + 2'h1 : 2'h0;
		if (io_wr === 1'b1 && io_ready === 1'b1) begin
			log[n] <= {io_addr, io_data};
			n <= n + 1;
		end
	end
endmodule : bos_part_model
